// ---- rtl/alu_pkg.sv ----
package alu_pkg;

	// datapath and bus widths
	localparam int DATA_W = 16;
	localparam int BUS_W  = 32;
	localparam int ADDR_W = 8;

	// operand select codes: register-file entries 0-9, then feedback register and instruction constant
	localparam logic [3:0] SEL_X0     = 4'h0;
	localparam logic [3:0] SEL_X1     = 4'h1;
	localparam logic [3:0] SEL_Y0     = 4'h2;
	localparam logic [3:0] SEL_Y1     = 4'h3;
	localparam logic [3:0] SEL_MR0    = 4'h4;
	localparam logic [3:0] SEL_MR1    = 4'h5;
	localparam logic [3:0] SEL_MR2    = 4'h6;
	localparam logic [3:0] SEL_SR0    = 4'h7;
	localparam logic [3:0] SEL_SR1    = 4'h8;
	localparam logic [3:0] SEL_RESULT = 4'h9;
	localparam logic [3:0] SEL_FEED   = 4'hA;
	localparam logic [3:0] SEL_CONST  = 4'hB;
	localparam int         FILE_N     = 10;

	// byte offsets on the bus; file entry n sits at n*4
	localparam logic [ADDR_W-1:0] OFS_FILE     = 8'h00;
	localparam logic [ADDR_W-1:0] OFS_FILE_END = 8'h24;
	localparam logic [ADDR_W-1:0] OFS_FEED     = 8'h28;
	localparam logic [ADDR_W-1:0] OFS_STATUS   = 8'h2C;
	localparam logic [ADDR_W-1:0] OFS_INSTR    = 8'h30;
	localparam logic [ADDR_W-1:0] OFS_IRQ_STAT = 8'h34;
	localparam logic [ADDR_W-1:0] OFS_IRQ_MASK = 8'h38;

	// reset values
	localparam logic [DATA_W-1:0] RESET_WORD   = 16'h0000;
	localparam logic [5:0]        RESET_STATUS = 6'h00;
	localparam logic [2:0]        RESET_IRQ    = 3'h0;

	// interrupt event bit positions
	localparam int EV_DONE     = 0;
	localparam int EV_OVERFLOW = 1;
	localparam int EV_ILLEGAL  = 2;

	// destinations of a result
	typedef enum logic [1:0] {
		DEST_RESULT = 2'b00,
		DEST_FEED   = 2'b01,
		DEST_NONE   = 2'b10
	} dest_e;

	// alu operations
	typedef enum logic [3:0] {
		OP_ADD  = 4'h0,
		OP_ADC  = 4'h1,
		OP_SUB  = 4'h2,
		OP_SBC  = 4'h3,
		OP_INC  = 4'h4,
		OP_DEC  = 4'h5,
		OP_AND  = 4'h6,
		OP_OR   = 4'h7,
		OP_XOR  = 4'h8,
		OP_NOT  = 4'h9,
		OP_ABS  = 4'hA,
		OP_PASS = 4'hB,
		OP_DIVIDE_SIGN_STEP = 4'hC,
		OP_DIVIDE_QUOTIENT_STEP = 4'hD
	} op_e;

	// status word, bit 0 upward: zero, sign, overflow, carry, x sign, quotient
	typedef struct packed {
		logic quotient_bit_flag;
		logic x_input_sign_flag;
		logic msb_cout_flag;
		logic overflow_flag;
		logic result_sign_flag;
		logic result_zero_flag;
	} flags_s;

	// instruction word as written to the instruction register
	typedef struct packed {
		logic [15:0] constant;
		logic        spare;
		logic        restricted;
		dest_e       dest;
		logic [3:0]  ysel;
		logic [3:0]  xsel;
		op_e         op;
	} instr_s;

endpackage

// ---- rtl/alu_adder.sv ----
`timescale 1ns/10ps
// 16-bit adder giving carry out of the top stage and overflow from the top two stages
module alu_adder (
	input  wire logic [15:0] a,
	input  wire logic [15:0] b,
	input  wire logic        cin,
	output logic      [15:0] sum,
	output logic             cout,
	output logic             ovf
);

	logic [15:0] low;
	logic [1:0]  top;

	// low 15 stages, then the top stage on its own so both carries are visible
	always_comb begin
		low = {1'b0, a[14:0]} + {1'b0, b[14:0]} + {15'h0000, cin};
		top = {1'b0, a[15]} + {1'b0, b[15]} + {1'b0, low[15]};
		sum = {top[0], low[14:0]};
		cout = top[1];
		ovf = top[1] ^ low[15];
	end

endmodule

// ---- rtl/alu_core.sv ----
`timescale 1ns/10ps
// Contract
// RQ1 - status write lands one cycle after bus write
// RQ2 - sixteen-bit datapath, ports X, Y, R
// RQ3 - carry in comes from stored carry flag
// RQ4 - six flags latched at cycle end
// RQ5 - result to result or feedback, none-destination flags only
// RQ6 - unrestricted: any file entry; Y also feedback
// RQ7 - restricted: X and Y limited register sets
// RQ8 - constant Y allowed with restricted-set X
// RQ9 - read at cycle start, written at end
// RQ10 - add-with-carry adds carry; borrow is carry-1
// RQ11 - two primitives form non-restoring division
// RQ12 - 32/16 division takes sixteen step cycles
// RQ13 - program places divisor, dividend, reads quotient
// RQ14 - sign step: quotient sign xor, into flag, shifted
// RQ15 - sign step shifts feedback/y0 pair left
// RQ16 - per-instruction flag policy, same for both destinations
// RQ17 - zero, sign, overflow, carry, x-sign meanings
// RQ18 - quotient step adds if flag set, else subtracts
// RQ19 - full operation set including divide steps
module alu_core (
	input  wire logic        clock,
	input  wire logic        reset,
	input  wire logic [7:0]  address,
	input  wire logic        read,
	input  wire logic        write,
	input  wire logic [31:0] writedata,
	input  wire logic [3:0]  byteenable,
	output logic      [31:0] readdata,
	output logic             waitrequest,
	output logic             irq,
	output logic      [15:0] result,
	output logic      [5:0]  status
);

	logic [15:0]  regfile [alu_pkg::FILE_N];
	logic [15:0]  feedback_reg;
	alu_pkg::flags_s compute_status_word;
	alu_pkg::flags_s status_pending;
	logic         status_load;
	alu_pkg::instr_s instr;
	logic         exec;
	logic [2:0]   irq_status;
	logic [2:0]   irq_mask;
	logic         accept;
	logic         wr_now;
	logic         rd_now;
	logic [31:0]  read_value;
	logic [15:0]  x_op;
	logic [15:0]  y_op;
	logic         x_in_set;
	logic         legal;
	logic [15:0]  add_a;
	logic [15:0]  add_b;
	logic         add_cin;
	logic [15:0]  add_sum;
	logic         add_cout;
	logic         add_ovf;
	logic [15:0]  r_out;
	logic         cin_signal;
	logic         is_arith;
	logic         writes_back;
	alu_pkg::flags_s next_flags;
	logic [15:0]  next_feedback;
	logic [15:0]  next_y0;
	logic         div_step;
	logic [2:0]   events;

	// an access completes on the second edge it is held: waitrequest drops for one cycle
	assign accept = (read | write) & ~waitrequest;
	assign wr_now = write & accept;
	assign rd_now = read & accept;

	always_ff @(posedge clock or posedge reset) begin
		if (reset) begin
			waitrequest <= 1'b1;
		end else begin
			waitrequest <= ~((read | write) & waitrequest);
		end
	end

	// carry in taken from the flag held now
	assign cin_signal = compute_status_word.msb_cout_flag; // see RQ3

	// operand fetch from the values stored at the previous edge
	always_comb begin
		x_op = alu_pkg::RESET_WORD;
		if (instr.xsel < alu_pkg::SEL_FEED) begin
			x_op = regfile[instr.xsel]; // see RQ6 see RQ9
		end
		case (instr.ysel)
			alu_pkg::SEL_FEED:  y_op = feedback_reg; // see RQ6
			alu_pkg::SEL_CONST: y_op = instr.constant; // see RQ8
			default: begin
				y_op = (instr.ysel < alu_pkg::SEL_FEED) ? regfile[instr.ysel] : alu_pkg::RESET_WORD;
			end
		endcase
		if (instr.op == alu_pkg::OP_DIVIDE_QUOTIENT_STEP) begin
			y_op = feedback_reg; // partial remainder
		end
	end

	// operand legality: restricted sets for conditional and multifunction forms
	always_comb begin
		x_in_set = (instr.xsel < alu_pkg::SEL_FEED) && (instr.xsel != alu_pkg::SEL_Y0)
			&& (instr.xsel != alu_pkg::SEL_Y1); // see RQ7
		legal = (instr.xsel < alu_pkg::SEL_FEED) && (instr.ysel <= alu_pkg::SEL_CONST);
		if (instr.ysel == alu_pkg::SEL_CONST && !x_in_set) begin
			legal = 1'b0; // see RQ8
		end
		if (instr.restricted) begin
			if (!x_in_set) begin
				legal = 1'b0; // see RQ7
			end
			if (instr.ysel != alu_pkg::SEL_Y0 && instr.ysel != alu_pkg::SEL_Y1
				&& instr.ysel != alu_pkg::SEL_FEED && instr.ysel != alu_pkg::SEL_CONST) begin
				legal = 1'b0; // see RQ7
			end
		end
		if (instr.dest == 2'b11) begin
			legal = 1'b0;
		end
	end

	// adder operand steering per operation
	always_comb begin
		add_a = x_op;
		add_b = y_op;
		add_cin = 1'b0;
		case (instr.op)
			alu_pkg::OP_ADC: add_cin = cin_signal; // see RQ10
			alu_pkg::OP_SUB: begin
				add_b = ~y_op;
				add_cin = 1'b1;
			end
			alu_pkg::OP_SBC: begin
				add_b = ~y_op;
				add_cin = cin_signal; // x - y + c - 1, see RQ10
			end
			alu_pkg::OP_INC: begin
				add_a = y_op;
				add_b = 16'h0000;
				add_cin = 1'b1;
			end
			alu_pkg::OP_DEC: begin
				add_a = y_op;
				add_b = 16'hFFFF;
			end
			alu_pkg::OP_ABS: begin
				add_a = x_op[15] ? 16'h0000 : x_op;
				add_b = x_op[15] ? ~x_op : 16'h0000;
				add_cin = x_op[15];
			end
			alu_pkg::OP_DIVIDE_QUOTIENT_STEP: begin
				add_a = y_op;
				add_b = compute_status_word.quotient_bit_flag ? x_op : ~x_op; // see RQ18
				add_cin = ~compute_status_word.quotient_bit_flag;
			end
			default: add_a = x_op;
		endcase
	end

	alu_adder adder (
		.a    (add_a),
		.b    (add_b),
		.cin  (add_cin),
		.sum  (add_sum),
		.cout (add_cout),
		.ovf  (add_ovf)
	);

	// result selection and flag policy
	always_comb begin
		is_arith = 1'b1;
		div_step = 1'b0;
		r_out = add_sum; // see RQ2
		case (instr.op)
			alu_pkg::OP_AND: begin
				r_out = x_op & y_op;
				is_arith = 1'b0;
			end
			alu_pkg::OP_OR: begin
				r_out = x_op | y_op;
				is_arith = 1'b0;
			end
			alu_pkg::OP_XOR: begin
				r_out = x_op ^ y_op;
				is_arith = 1'b0;
			end
			alu_pkg::OP_NOT: begin
				r_out = ~x_op;
				is_arith = 1'b0;
			end
			alu_pkg::OP_PASS: begin
				r_out = y_op;
				is_arith = 1'b0;
			end
			alu_pkg::OP_DIVIDE_SIGN_STEP: begin
				r_out = y_op; // y passes straight through, see RQ15
				div_step = 1'b1;
			end
			alu_pkg::OP_DIVIDE_QUOTIENT_STEP: div_step = 1'b1;
			default: r_out = add_sum; // see RQ19
		endcase
		next_flags = compute_status_word;
		if (div_step) begin
			if (instr.op == alu_pkg::OP_DIVIDE_SIGN_STEP) begin
				next_flags.quotient_bit_flag = x_op[15] ^ y_op[15]; // see RQ14
			end else begin
				next_flags.quotient_bit_flag = x_op[15] ^ r_out[15]; // see RQ11
			end
		end else begin
			next_flags.result_zero_flag = (r_out == 16'h0000); // see RQ17
			next_flags.result_sign_flag = r_out[15]; // see RQ17
			next_flags.overflow_flag = is_arith & add_ovf; // see RQ16 see RQ17
			next_flags.msb_cout_flag = is_arith & add_cout & (instr.op != alu_pkg::OP_ABS); // see RQ16
			if (instr.op == alu_pkg::OP_ABS) begin
				next_flags.x_input_sign_flag = x_op[15]; // see RQ17
			end
		end
		// each step shifts the feedback/y0 pair left one place, see RQ15
		next_feedback = {r_out[14:0], regfile[alu_pkg::SEL_Y0][15]};
		next_y0 = {regfile[alu_pkg::SEL_Y0][14:0], (instr.op == alu_pkg::OP_DIVIDE_SIGN_STEP)
			? next_flags.quotient_bit_flag : ~next_flags.quotient_bit_flag}; // see RQ14 see RQ12
		writes_back = exec & legal & ~div_step & (instr.dest != alu_pkg::DEST_NONE); // see RQ5
	end

	// instruction register: a write issues one operation in the following cycle
	always_ff @(posedge clock or posedge reset) begin
		if (reset) begin
			instr <= '0;
			exec <= 1'b0;
		end else begin
			exec <= wr_now && address == alu_pkg::OFS_INSTR;
			if (wr_now && address == alu_pkg::OFS_INSTR) begin
				instr <= writedata;
			end
		end
	end

	// operand registers: new values written at the edge ending the cycle, see RQ9
	generate
		for (genvar i = 0; i < alu_pkg::FILE_N; i++) begin : file_entry
			always_ff @(posedge clock or posedge reset) begin
				if (reset) begin
					regfile[i] <= alu_pkg::RESET_WORD;
				end else if (i == alu_pkg::SEL_RESULT && writes_back && instr.dest == alu_pkg::DEST_RESULT) begin
					regfile[i] <= r_out; // see RQ5
				end else if (i == alu_pkg::SEL_Y0 && exec && legal && div_step) begin
					regfile[i] <= next_y0; // quotient collects here, see RQ13
				end else if (wr_now && address == 8'(i * 4)) begin
					if (byteenable[0]) begin
						regfile[i][7:0] <= writedata[7:0];
					end
					if (byteenable[1]) begin
						regfile[i][15:8] <= writedata[15:8];
					end
				end
			end
		end
	endgenerate

	// internal feedback register
	always_ff @(posedge clock or posedge reset) begin
		if (reset) begin
			feedback_reg <= alu_pkg::RESET_WORD;
		end else if (exec && legal && div_step) begin
			feedback_reg <= next_feedback; // see RQ15
		end else if (writes_back && instr.dest == alu_pkg::DEST_FEED) begin
			feedback_reg <= r_out; // see RQ5
		end else if (wr_now && address == alu_pkg::OFS_FEED) begin
			if (byteenable[0]) begin
				feedback_reg[7:0] <= writedata[7:0];
			end
			if (byteenable[1]) begin
				feedback_reg[15:8] <= writedata[15:8];
			end
		end
	end

	// status word: alu flags latch at cycle end; software writes wait one extra cycle
	always_ff @(posedge clock or posedge reset) begin
		if (reset) begin
			compute_status_word <= alu_pkg::RESET_STATUS;
			status_pending <= alu_pkg::RESET_STATUS;
			status_load <= 1'b0;
		end else begin
			status_load <= wr_now && address == alu_pkg::OFS_STATUS && byteenable[0];
			if (wr_now && address == alu_pkg::OFS_STATUS && byteenable[0]) begin
				status_pending <= writedata[5:0];
			end
			if (status_load) begin
				compute_status_word <= status_pending; // see RQ1
			end else if (exec && legal) begin
				compute_status_word <= next_flags; // see RQ4 see RQ16
			end
		end
	end

	// interrupt events
	assign events[alu_pkg::EV_DONE] = exec & legal;
	assign events[alu_pkg::EV_OVERFLOW] = exec & legal & ~div_step & next_flags.overflow_flag;
	assign events[alu_pkg::EV_ILLEGAL] = exec & ~legal;

	// sticky status cleared by a read; a new event in that cycle wins
	always_ff @(posedge clock or posedge reset) begin
		if (reset) begin
			irq_status <= alu_pkg::RESET_IRQ;
			irq_mask <= alu_pkg::RESET_IRQ;
		end else begin
			if (rd_now && address == alu_pkg::OFS_IRQ_STAT) begin
				irq_status <= (irq_status & ~readdata[2:0]) | events; // only the reported bits clear
			end else begin
				irq_status <= irq_status | events;
			end
			if (wr_now && address == alu_pkg::OFS_IRQ_MASK && byteenable[0]) begin
				irq_mask <= writedata[2:0];
			end
		end
	end

	// interrupt line follows the masked sticky bits, changing at the same edge they do
	always_ff @(posedge clock or posedge reset) begin
		if (reset) begin
			irq <= 1'b0;
		end else begin
			irq <= |(((irq_status & ~((rd_now && address == alu_pkg::OFS_IRQ_STAT) ? readdata[2:0] : 3'h0))
				| events) & irq_mask);
		end
	end

	// read mux; unmapped offsets read zero
	always_comb begin
		read_value = 32'h00000000;
		if (address <= alu_pkg::OFS_FILE_END && address[1:0] == 2'b00) begin
			read_value = {16'h0000, regfile[address[5:2]]};
		end else begin
			case (address)
				alu_pkg::OFS_FEED:     read_value = {16'h0000, feedback_reg};
				alu_pkg::OFS_STATUS:   read_value = {26'h0000000, compute_status_word};
				alu_pkg::OFS_INSTR:    read_value = instr;
				alu_pkg::OFS_IRQ_STAT: read_value = {29'h00000000, irq_status};
				alu_pkg::OFS_IRQ_MASK: read_value = {29'h00000000, irq_mask};
				default:               read_value = 32'h00000000;
			endcase
		end
	end

	// read data captured while waitrequest is still high, stands through the answering edge
	always_ff @(posedge clock or posedge reset) begin
		if (reset) begin
			readdata <= 32'h00000000;
		end else if (read && waitrequest) begin
			readdata <= read_value;
		end
	end

	// mirrored outputs for the sequencer
	always_ff @(posedge clock or posedge reset) begin
		if (reset) begin
			result <= alu_pkg::RESET_WORD;
			status <= alu_pkg::RESET_STATUS;
		end else begin
			result <= regfile[alu_pkg::SEL_RESULT];
			status <= compute_status_word;
		end
	end
endmodule

// ---- bench/alu_core_checker.sv ----
`timescale 1ns/10ps
module alu_core_checker (
	input wire logic        clock,
	input wire logic        reset,
	input wire logic [7:0]  address,
	input wire logic        read,
	input wire logic        write,
	input wire logic [31:0] writedata,
	input wire logic [3:0]  byteenable,
	input wire logic [31:0] readdata,
	input wire logic        waitrequest,
	input wire logic        irq,
	input wire logic [15:0] result,
	input wire logic [5:0]  status
);
	default clocking cb @(posedge clock); endclocking
	default disable iff (reset);
	// completed read at a given address
	sequence s_rd(logic [7:0] a);
		read && !waitrequest && address == a;
	endsequence
	// completed write to the status word
	sequence s_status_wr;
		write && !waitrequest && byteenable[0] && address == alu_pkg::OFS_STATUS;
	endsequence
	a_wait_one: assert property ((read || write) && waitrequest |=> !waitrequest)
		else $error("no answer after one wait");
	a_wait_release: assert property (!waitrequest |=> waitrequest)
		else $error("wait low too long");
	a_readdata_hold: assert property (!(read && waitrequest) |=> $stable(readdata))
		else $error("read data moved");
	a_status_latency: assert property (s_status_wr |=> ##1 $stable(status) ##1 status == $past(writedata[5:0], 3))
		else $error("status write landed at wrong edge");
	a_status_cause: assert property (!$stable(status) |-> $past(write && !waitrequest && (address == alu_pkg::OFS_STATUS || address == alu_pkg::OFS_INSTR), 3))
		else $error("status moved without cause");
	a_result_read: assert property (s_rd(alu_pkg::OFS_FILE_END) |-> readdata == {16'h0000, result})
		else $error("result read mismatch");
	a_status_read: assert property (s_rd(alu_pkg::OFS_STATUS) |-> readdata == {26'h0000000, status})
		else $error("status read mismatch");
	a_irq_clear: assert property (s_rd(alu_pkg::OFS_IRQ_STAT) |-> ##2 !irq)
		else $error("irq not cleared by read");
	a_unmapped_zero: assert property (read && !waitrequest && address > alu_pkg::OFS_IRQ_MASK |-> readdata == 32'h0)
		else $error("unmapped read not zero");
	a_upper_zero: assert property (read && !waitrequest && address != alu_pkg::OFS_INSTR |-> readdata[31:16] == 16'h0)
		else $error("upper read bits not zero");
endmodule
bind alu_core alu_core_checker checker_i (.clock(clock), .reset(reset), .address(address), .read(read),
	.write(write), .writedata(writedata), .byteenable(byteenable), .readdata(readdata),
	.waitrequest(waitrequest), .irq(irq), .result(result), .status(status));

// ---- bench/alu_bus_master.sv ----
`timescale 1ns/10ps
// program side: one bus access per go pulse, done when it ends
module alu_bus_master (
	input  wire logic        clock,
	input  wire logic        reset,
	input  wire logic        go,
	input  wire logic        cmd_write,
	input  wire logic [7:0]  cmd_addr,
	input  wire logic [31:0] cmd_data,
	output logic             done,
	output logic      [31:0] rdata,
	output logic      [7:0]  address,
	output logic             read,
	output logic             write,
	output logic      [31:0] writedata,
	output logic      [3:0]  byteenable,
	input  wire logic [31:0] readdata,
	input  wire logic        waitrequest
);
	assign byteenable = 4'hF;
	// request held until waitrequest is seen low; data inverted once released
	always_ff @(posedge clock or posedge reset) begin
		if (reset) begin
			read <= 1'b0;
			write <= 1'b0;
			done <= 1'b0;
			address <= 8'h00;
			writedata <= 32'h0;
			rdata <= 32'h0;
		end else begin
			done <= 1'b0;
			if ((read || write) && !waitrequest) begin
				read <= 1'b0;
				write <= 1'b0;
				done <= 1'b1;
				rdata <= readdata;
				writedata <= ~writedata;
				address <= ~address;
			end else if (go && !read && !write) begin
				read <= !cmd_write;
				write <= cmd_write;
				address <= cmd_addr;
				writedata <= cmd_data;
			end
		end
	end
endmodule

// ---- bench/fixed_point_alu_divide_steps_bench.sv ----
`timescale 1ns/10ps
module fixed_point_alu_divide_steps_bench;
	typedef struct packed {
		logic [3:0]  op;
		logic [15:0] x;
		logic [15:0] y;
		logic [5:0]  pre;
		logic [15:0] r;
		logic [5:0]  f;
	} row_s;
	logic        clock, reset, go, cmd_write, done, read, write, waitrequest, irq;
	logic [7:0]  cmd_addr, address;
	logic [31:0] cmd_data, rdata, writedata, readdata, q;
	logic [3:0]  byteenable;
	logic [15:0] result;
	logic [5:0]  status;
	int          fail_count, n_compared;
	// op, x, y, preset status, expected result, expected flags
	row_s rows [13] = '{
		'{4'h0, 16'h7FFF, 16'h0001, 6'h00, 16'h8000, 6'h06},
		'{4'h1, 16'hFFFF, 16'h0001, 6'h08, 16'h0001, 6'h08},
		'{4'h2, 16'h0005, 16'h0005, 6'h00, 16'h0000, 6'h09},
		'{4'h3, 16'h0005, 16'h0005, 6'h00, 16'hFFFF, 6'h02},
		'{4'h4, 16'h1234, 16'hFFFF, 6'h00, 16'h0000, 6'h09},
		'{4'h5, 16'h1234, 16'h0000, 6'h00, 16'hFFFF, 6'h02},
		'{4'h6, 16'hF0F0, 16'h3C3C, 6'h0C, 16'h3030, 6'h00},
		'{4'h7, 16'hF0F0, 16'h0F0F, 6'h0C, 16'hFFFF, 6'h02},
		'{4'h8, 16'hAAAA, 16'hAAAA, 6'h0C, 16'h0000, 6'h01},
		'{4'h9, 16'h0000, 16'h1234, 6'h00, 16'hFFFF, 6'h02},
		'{4'hA, 16'h8001, 16'h0000, 6'h08, 16'h7FFF, 6'h10},
		'{4'hA, 16'h8000, 16'h0000, 6'h00, 16'h8000, 6'h16},
		'{4'hB, 16'h1234, 16'h0000, 6'h2C, 16'h0000, 6'h21}};
	alu_core uut (.clock(clock), .reset(reset), .address(address), .read(read), .write(write),
		.writedata(writedata), .byteenable(byteenable), .readdata(readdata), .waitrequest(waitrequest),
		.irq(irq), .result(result), .status(status));
	alu_bus_master model (.clock(clock), .reset(reset), .go(go), .cmd_write(cmd_write), .cmd_addr(cmd_addr),
		.cmd_data(cmd_data), .done(done), .rdata(rdata), .address(address), .read(read), .write(write),
		.writedata(writedata), .byteenable(byteenable), .readdata(readdata), .waitrequest(waitrequest));
	// clock
	initial begin
		clock = 1'b0;
		forever #20 clock = ~clock;
	end
	task automatic conclude();
		if (fail_count == 0 && n_compared > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_compared++;
		if (got !== exp) begin
			fail_count++;
			$display("[ERR] %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] o);
		int n;
		n = 0;
		@(posedge clock);
		cmd_write <= w;
		cmd_addr <= a;
		cmd_data <= d;
		go <= 1'b1;
		@(posedge clock);
		go <= 1'b0;
		do begin
			@(negedge clock);
			n++;
		end while (done !== 1'b1 && n < 20);
		if (n >= 20) begin
			fail_count++;
			conclude();
		end else begin
			o = rdata;
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		bus(1'b1, a, d, q);
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		bus(1'b0, a, 32'h0, q);
		chk(q, e);
	endtask
	function automatic logic [31:0] ins(input logic [3:0] op, input logic [3:0] xs, input logic [3:0] ys,
		input logic [1:0] de, input logic rs, input logic [15:0] k);
		return {k, 1'b0, rs, de, ys, xs, op};
	endfunction
	// main sequence
	initial begin
		reset = 1'b1;
		go = 1'b0;
		cmd_write = 1'b0;
		cmd_addr = 8'h00;
		cmd_data = 32'h0;
		fail_count = 0;
		n_compared = 0;
		repeat (4) @(posedge clock);
		@(negedge clock);
		chk(readdata, 32'h0);
		chk({8'h00, waitrequest, irq, result, status}, 32'h00800000);
		@(posedge clock);
		reset <= 1'b0;
		for (int i = 0; i < 13; i++) begin
			wr(8'h00, {16'h0000, rows[i].x});
			wr(8'h08, {16'h0000, rows[i].y});
			wr(8'h2C, {26'h0, rows[i].pre});
			wr(8'h30, ins(rows[i].op, 4'h0, 4'h2, 2'h0, 1'b0, 16'h0000));
			rd(8'h24, {16'h0000, rows[i].r});
			rd(8'h2C, {26'h0, rows[i].f});
			chk({16'h0000, result}, {16'h0000, rows[i].r});
		end
		// signed 200 by 7: one sign step, fifteen quotient steps
		wr(8'h00, 32'h7);
		wr(8'h28, 32'h0);
		wr(8'h08, 32'hC8);
		wr(8'h2C, 32'h0);
		wr(8'h30, ins(4'hC, 4'h0, 4'hA, 2'h0, 1'b0, 16'h0000));
		for (int i = 0; i < 15; i++) wr(8'h30, ins(4'hD, 4'h0, 4'hA, 2'h0, 1'b0, 16'h0000));
		rd(8'h08, 32'hE);
		// sign step with negative divisor shifts the pair
		wr(8'h00, 32'h8000);
		wr(8'h28, 32'h4000);
		wr(8'h08, 32'h8000);
		wr(8'h2C, 32'h0);
		wr(8'h30, ins(4'hC, 4'h0, 4'hA, 2'h0, 1'b0, 16'h0000));
		rd(8'h28, 32'h8001);
		rd(8'h08, 32'h1);
		rd(8'h2C, 32'h20);
		// status write seen two edges later
		wr(8'h2C, 32'h3F);
		chk({26'h0, status}, 32'h20);
		@(negedge clock);
		chk({26'h0, status}, 32'h20);
		@(negedge clock);
		chk({26'h0, status}, 32'h3F);
		// restricted forms, interrupt raise, clear and mask
		wr(8'h38, 32'h7);
		rd(8'h34, 32'h3);
		wr(8'h30, ins(4'hB, 4'h0, 4'hB, 2'h1, 1'b1, 16'h1234));
		rd(8'h28, 32'h1234);
		chk({31'h0, irq}, 32'h1);
		rd(8'h34, 32'h1);
		@(negedge clock);
		chk({31'h0, irq}, 32'h0);
		wr(8'h30, ins(4'h0, 4'h2, 4'h3, 2'h0, 1'b1, 16'h0000));
		rd(8'h24, 32'h0);
		rd(8'h34, 32'h4);
		wr(8'h38, 32'h0);
		wr(8'h30, ins(4'hB, 4'h0, 4'h2, 2'h2, 1'b0, 16'h0000));
		rd(8'h24, 32'h0);
		chk({31'h0, irq}, 32'h0);
		rd(8'h34, 32'h1);
		rd(8'h3C, 32'h0);
		conclude();
	end
endmodule
